// >>> design/cpwm_pkg.sv
// Shared constants and carrier types for the complementary PWM and phase counter block
package cpwm_pkg;
   // ==========================================================
   // Widths and reset values
   localparam int CPWM_CNT_W = 16;
   localparam logic [15:0] CPWM_CNT_RST = 16'h0000;
   localparam logic [15:0] CPWM_CNT_ONE = 16'h0001;
   localparam logic [15:0] CPWM_CNT_MAX = 16'hffff;
   // Ceiling of the lead counter is the compare value plus this step
   localparam logic [15:0] CPWM_CEIL_STEP = 16'h0001;

   // ==========================================================
   // Counting direction states
   typedef enum logic [0:0] {
      CPWM_DIR_UP = 1'b0,
      CPWM_DIR_DOWN = 1'b1
   } cpwm_dir_type;

   // Transition values for the three output pairs
   typedef struct packed {
      logic [15:0] phase_one_compare;
      logic [15:0] phase_two_compare;
      logic [15:0] phase_three_compare;
   } cpwm_cmp_type;

   // Six complementary outputs
   typedef struct packed {
      logic phase_one_out;
      logic phase_one_out_n;
      logic phase_two_out;
      logic phase_two_out_n;
      logic phase_three_out;
      logic phase_three_out_n;
   } cpwm_out_type;
endpackage

// >>> design/cpwm_quad_decoder.sv
// Quadrature edge decoder producing count step and direction
`timescale 1ns/1ps
module cpwm_quad_decoder
   import cpwm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic enable,
   input wire logic quad_in_a,
   input wire logic quad_in_b,
   output logic step,
   output logic step_up
);
   logic a_q;
   logic b_q;
   logic a_edge;
   logic b_edge;

   // ==========================================================
   // Previous input levels; inputs are synchronous to ref_clk
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
      end else if (clk_en) begin
         a_q <= quad_in_a;
         b_q <= quad_in_b;
      end
   end

   // Step on any edge of either input; both at once is ignored as illegal
   always_comb begin
      a_edge = a_q ^ quad_in_a;
      b_edge = b_q ^ quad_in_b;
      step = enable & (a_edge ^ b_edge);
      // B leading A counts up: an A edge lands on B's level, a B edge leaves A's
      if (a_edge) begin
         step_up = ~(quad_in_a ^ quad_in_b);
      end else begin
         step_up = quad_in_a ^ quad_in_b;
      end
   end
endmodule

// >>> design/cpwm_timer.sv
// Complementary PWM counter pair and channel-two phase counter
`timescale 1ns/1ps
module cpwm_timer
   import cpwm_pkg::*;
#(
   parameter int CNT_W = CPWM_CNT_W
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic cpwm_mode,
   input wire logic buffer_en,
   input wire logic preset_we,
   input wire logic [CNT_W-1:0] lead_preset,
   input wire logic [CNT_W-1:0] lag_preset,
   input wire logic [CNT_W-1:0] ceiling_compare,
   input wire logic cmp_we,
   input wire cpwm_cmp_type cmp_wdata,
   input wire cpwm_cmp_type buf_wdata,
   input wire logic buf_we,
   input wire logic polarity_sel_lead,
   input wire logic polarity_sel_lag,
   input wire logic match_a_clr,
   input wire logic wrap_clr,
   input wire logic quad_mode,
   input wire logic quad_in_a,
   input wire logic quad_in_b,
   input wire logic [1:0] clear_src,
   input wire logic [CNT_W-1:0] quad_compare_a,
   input wire logic [CNT_W-1:0] quad_compare_b,
   input wire logic quad_flags_clr,
   output logic [CNT_W-1:0] lead_counter,
   output logic [CNT_W-1:0] lag_counter,
   output cpwm_dir_type count_dir,
   output cpwm_cmp_type active_compares,
   output logic match_a_flag,
   output logic wrap_flag,
   output logic pwm_pins_enabled,
   output cpwm_out_type pwm_out,
   output logic [CNT_W-1:0] quadrature_counter,
   output logic [2:0] quad_status
);
   logic [CNT_W-1:0] lead_q;
   logic [CNT_W-1:0] lag_q;
   cpwm_dir_type dir_q;
   cpwm_cmp_type cmp_q;
   cpwm_cmp_type buf_q;
   logic match_a_q;
   logic wrap_q;
   logic [2:0] pair_q;
   cpwm_out_type out_q;
   logic [CNT_W-1:0] quad_q;
   logic [2:0] qstat_q;
   logic ceil_hit;
   logic underflow;
   logic [2:0] lead_hit;
   logic [2:0] lag_hit;
   logic q_step;
   logic q_up;
   logic q_match_a;
   logic q_match_b;
   logic q_wrap;

   // Equality compare used for turnaround and match points; pin levels use magnitude compares
   function automatic logic hit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmpv);
      hit = (cnt == cmpv);
   endfunction

   // Lag above a compare; all ones is the undershoot and reads as minus one
   function automatic logic lag_above(input logic [CNT_W-1:0] cnt,
                                      input logic [CNT_W-1:0] cmpv);
      lag_above = (cnt > cmpv) && (cnt != '1);
   endfunction

   // ==========================================================
   // Turnaround detection
   always_comb begin
      // Reverse one step past the compare value: ceiling is value plus one
      ceil_hit = cpwm_mode && (dir_q == CPWM_DIR_UP)
                 && hit(lead_q, ceiling_compare + CPWM_CEIL_STEP);
      underflow = cpwm_mode && (dir_q == CPWM_DIR_DOWN)
                  && hit(lag_q, CPWM_CNT_RST);
   end

   // Per-pair matches: lead counter leads the way, lag counter follows
   always_comb begin
      lead_hit[0] = hit(lead_q, cmp_q.phase_one_compare);
      lead_hit[1] = hit(lead_q, cmp_q.phase_two_compare);
      lead_hit[2] = hit(lead_q, cmp_q.phase_three_compare);
      lag_hit[0] = hit(lag_q, cmp_q.phase_one_compare);
      lag_hit[1] = hit(lag_q, cmp_q.phase_two_compare);
      lag_hit[2] = hit(lag_q, cmp_q.phase_three_compare);
   end

   // ==========================================================
   // Up/down counters; preset loads are the software start step
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lead_q <= CPWM_CNT_RST;
         lag_q <= CPWM_CNT_RST;
      end else if (clk_en) begin
         if (preset_we) begin
            lead_q <= lead_preset;
            lag_q <= lag_preset;
         end else if (cpwm_mode) begin
            // Down on the underflow step too, so lag dips to all ones before turning
            if ((dir_q == CPWM_DIR_UP) && !ceil_hit) begin
               lead_q <= lead_q + CPWM_CNT_ONE;
               lag_q <= lag_q + CPWM_CNT_ONE;
            end else begin
               lead_q <= lead_q - CPWM_CNT_ONE;
               lag_q <= lag_q - CPWM_CNT_ONE;
            end
         end
      end
   end

   // Direction state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dir_q <= CPWM_DIR_UP;
      end else if (clk_en) begin
         if (!cpwm_mode || preset_we) begin
            dir_q <= CPWM_DIR_UP;
         end else if (ceil_hit) begin
            dir_q <= CPWM_DIR_DOWN;
         end else if (underflow) begin
            dir_q <= CPWM_DIR_UP;
         end
      end
   end

   // ==========================================================
   // Buffer and compare registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         buf_q <= '0;
      end else if (clk_en && buf_we) begin
         buf_q <= buf_wdata;
      end
   end

   // Transfers only at the two turnarounds; a direct write is still allowed
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmp_q <= '0;
      end else if (clk_en) begin
         if (buffer_en && (ceil_hit || underflow)) begin
            cmp_q <= buf_q;
         end else if (cmp_we) begin
            cmp_q <= cmp_wdata;
         end
      end
   end

   // ==========================================================
   // Status flags: the set wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         match_a_q <= 1'b0;
         wrap_q <= 1'b0;
      end else if (clk_en) begin
         if (ceil_hit) begin
            match_a_q <= 1'b1;
         end else if (match_a_clr) begin
            match_a_q <= 1'b0;
         end
         if (underflow) begin
            wrap_q <= 1'b1;
         end else if (wrap_clr) begin
            wrap_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Pair state: lead match sets the pair bit on the way up and clears it
   // on the way down; lag matches are not used. A value above the
   // ceiling never matches, so the pair holds its level.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pair_q <= 3'h0;
      end else if (clk_en) begin
         if (!cpwm_mode) begin
            pair_q <= 3'h0;
         end else begin
            for (int i = 0; i < 3; i++) begin
               if (dir_q == CPWM_DIR_UP && lead_hit[i]) begin
                  pair_q[i] <= 1'b1;
               end else if (dir_q == CPWM_DIR_DOWN && lead_hit[i]) begin
                  pair_q[i] <= 1'b0;
               end
            end
         end
      end
   end

   // Outputs: primary on while lead is below compare, partner on while lag is
   // above it; the margin between counters forms the dead time
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_q <= '0;
      end else if (clk_en) begin
         if (!cpwm_mode) begin
            out_q <= '0;
         end else begin
            out_q.phase_one_out <= polarity_sel_lead
               ~^ (lead_q < cmp_q.phase_one_compare);
            out_q.phase_one_out_n <= polarity_sel_lead
               ~^ (lag_above(lag_q, cmp_q.phase_one_compare) && pair_q[0]);
            out_q.phase_two_out <= polarity_sel_lag
               ~^ (lead_q < cmp_q.phase_two_compare);
            out_q.phase_two_out_n <= polarity_sel_lag
               ~^ (lag_above(lag_q, cmp_q.phase_two_compare) && pair_q[1]);
            out_q.phase_three_out <= polarity_sel_lag
               ~^ (lead_q < cmp_q.phase_three_compare);
            out_q.phase_three_out_n <= polarity_sel_lag
               ~^ (lag_above(lag_q, cmp_q.phase_three_compare) && pair_q[2]);
         end
      end
   end

   // ==========================================================
   // Channel-two phase counting; prescaler and edge fields have no say
   cpwm_quad_decoder u_quad (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .enable(quad_mode),
      .quad_in_a(quad_in_a),
      .quad_in_b(quad_in_b),
      .step(q_step),
      .step_up(q_up)
   );

   always_comb begin
      q_match_a = q_step && hit(quadrature_counter, quad_compare_a);
      q_match_b = q_step && hit(quadrature_counter, quad_compare_b);
      q_wrap = q_step && ((q_up && hit(quad_q, CPWM_CNT_MAX))
               || (!q_up && hit(quad_q, CPWM_CNT_RST)));
   end

   // Counter with clear source still honoured (1: match A, 2: match B)
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         quad_q <= CPWM_CNT_RST;
      end else if (clk_en && q_step) begin
         if ((clear_src == 2'h1 && q_match_a) || (clear_src == 2'h2 && q_match_b)) begin
            quad_q <= CPWM_CNT_RST;
         end else if (q_up) begin
            quad_q <= quad_q + CPWM_CNT_ONE;
         end else begin
            quad_q <= quad_q - CPWM_CNT_ONE;
         end
      end
   end

   // Status: bit0 match A, bit1 match B, bit2 wrap; set wins over clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         qstat_q <= 3'h0;
      end else if (clk_en) begin
         qstat_q <= (quad_flags_clr ? 3'h0 : qstat_q)
                    | {q_wrap, q_match_b, q_match_a};
      end
   end

   // ==========================================================
   // Output assignments
   assign lead_counter = lead_q;
   assign lag_counter = lag_q;
   assign count_dir = dir_q;
   assign active_compares = cmp_q;
   assign match_a_flag = match_a_q;
   assign wrap_flag = wrap_q;
   assign pwm_pins_enabled = cpwm_mode;
   assign pwm_out = out_q;
   assign quadrature_counter = quad_q;
   assign quad_status = qstat_q;
endmodule

// >>> testbench/cpwm_quad_source.sv
// Quadrature encoder model that drives the two phase inputs of the timer
`timescale 1ns/1ps
module cpwm_quad_source (
   input wire logic ref_clk,
   output logic quad_in_a,
   output logic quad_in_b
);
   // ==========================================================
   // Gray position: 00, b, ab, a going up, so b leads a
   logic [1:0] pos = 2'h0;
   assign quad_in_a = pos[1];
   assign quad_in_b = pos[1] ^ pos[0];

   // One line moves per step, then holds for three states to keep gaps legal
   task automatic move(input int n, input bit up);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         #1;
         pos = up ? pos + 2'h1 : pos - 2'h1;
         repeat (3) @(posedge ref_clk);
      end
   endtask
endmodule

// >>> testbench/cpwm_timer_asserts.sv
// Concurrent checks on the ports of the complementary PWM timer
`timescale 1ns/1ps
module cpwm_timer_asserts
   import cpwm_pkg::*;
#(
   parameter int CNT_W = CPWM_CNT_W
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic cpwm_mode,
   input wire logic buffer_en,
   input wire logic preset_we,
   input wire logic [CNT_W-1:0] ceiling_compare,
   input wire logic cmp_we,
   input wire logic polarity_sel_lead,
   input wire logic polarity_sel_lag,
   input wire logic quad_mode,
   input wire logic [1:0] clear_src,
   input wire logic [CNT_W-1:0] lead_counter,
   input wire logic [CNT_W-1:0] lag_counter,
   input wire cpwm_dir_type count_dir,
   input wire cpwm_cmp_type active_compares,
   input wire logic match_a_flag,
   input wire logic wrap_flag,
   input wire logic pwm_pins_enabled,
   input wire cpwm_out_type pwm_out,
   input wire logic [CNT_W-1:0] quadrature_counter
);
   // ==========================================================
   // Single clock domain, so one default clock and reset
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_PINS: assert property (pwm_pins_enabled == cpwm_mode)
      else $error("pin enable does not follow mode");
   AST_NO_OVERLAP: assert property (polarity_sel_lead && polarity_sel_lag |->
      !(pwm_out.phase_one_out && pwm_out.phase_one_out_n) &&
      !(pwm_out.phase_two_out && pwm_out.phase_two_out_n) &&
      !(pwm_out.phase_three_out && pwm_out.phase_three_out_n))
      else $error("pair active together");
   AST_CEIL_TURN: assert property (clk_en && cpwm_mode && !preset_we &&
      count_dir == CPWM_DIR_UP && lead_counter == ceiling_compare + CNT_W'(1)
      |=> count_dir == CPWM_DIR_DOWN && match_a_flag)
      else $error("no turn down at ceiling");
   AST_UNDER_TURN: assert property (clk_en && cpwm_mode && !preset_we &&
      count_dir == CPWM_DIR_DOWN && lag_counter == '0 |=> count_dir == CPWM_DIR_UP && wrap_flag
      && lag_counter == '1)
      else $error("no turn up at underflow");
   AST_STEP_UP: assert property (clk_en && cpwm_mode && !preset_we &&
      count_dir == CPWM_DIR_UP && lead_counter != ceiling_compare + CNT_W'(1) |=>
      lead_counter == $past(lead_counter) + CNT_W'(1) &&
      lag_counter == $past(lag_counter) + CNT_W'(1))
      else $error("counters did not step up");
   AST_STEP_DOWN: assert property (clk_en && cpwm_mode && !preset_we &&
      count_dir == CPWM_DIR_DOWN && lag_counter != '0 |=>
      lead_counter == $past(lead_counter) - CNT_W'(1) &&
      lag_counter == $past(lag_counter) - CNT_W'(1))
      else $error("counters did not step down");
   AST_FLAG_UP: assert property ($rose(match_a_flag) |-> $past(count_dir) == CPWM_DIR_UP)
      else $error("match flag set while down");
   AST_WRAP_DOWN: assert property ($rose(wrap_flag) |-> $past(count_dir) == CPWM_DIR_DOWN)
      else $error("wrap flag set while up");
   AST_BUF_COPY: assert property ($changed(active_compares) && !$past(cmp_we) |->
      $past(buffer_en) && $past(count_dir) != count_dir)
      else $error("compares changed off a turnaround");
   AST_QUAD_STEP: assert property (quad_mode && clear_src == 2'h0 &&
      $changed(quadrature_counter) |->
      quadrature_counter == $past(quadrature_counter) + CNT_W'(1) ||
      quadrature_counter == $past(quadrature_counter) - CNT_W'(1))
      else $error("phase counter jumped");
endmodule

bind cpwm_timer cpwm_timer_asserts #(.CNT_W(CNT_W)) u_asserts (
   .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .cpwm_mode(cpwm_mode),
   .buffer_en(buffer_en), .preset_we(preset_we), .ceiling_compare(ceiling_compare),
   .cmp_we(cmp_we), .polarity_sel_lead(polarity_sel_lead), .polarity_sel_lag(polarity_sel_lag),
   .quad_mode(quad_mode), .clear_src(clear_src), .lead_counter(lead_counter),
   .lag_counter(lag_counter), .count_dir(count_dir), .active_compares(active_compares),
   .match_a_flag(match_a_flag), .wrap_flag(wrap_flag), .pwm_pins_enabled(pwm_pins_enabled),
   .pwm_out(pwm_out), .quadrature_counter(quadrature_counter)
);

// >>> testbench/cpwm_timer_tb.sv
// Self-checking testbench for the complementary PWM and phase counter timer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fails++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module cpwm_timer_tb
   import cpwm_pkg::*;
;
   // ==========================================================
   // Stimulus, outputs and counters
   logic ref_clk, rst = 1'b1, clk_en = 1'b1, cpwm_mode = 1'b0, buffer_en = 1'b0;
   logic preset_we = 1'b0, cmp_we = 1'b0, buf_we = 1'b0, match_a_clr = 1'b0, wrap_clr = 1'b0;
   logic polarity_sel_lead = 1'b1, polarity_sel_lag = 1'b1, quad_mode = 1'b0;
   logic quad_flags_clr = 1'b0, quad_in_a, quad_in_b, match_a_flag, wrap_flag, pwm_pins_enabled;
   logic [1:0] clear_src = 2'h0;
   logic [15:0] lead_preset = 16'h0, lag_preset = 16'h0, ceiling_compare = 16'h0;
   logic [15:0] quad_compare_a = 16'h0, quad_compare_b = 16'h0;
   logic [15:0] lead_counter, lag_counter, quadrature_counter;
   logic [2:0] quad_status;
   cpwm_cmp_type cmp_wdata = '0, buf_wdata = '0, active_compares;
   cpwm_dir_type count_dir;
   cpwm_out_type pwm_out;
   logic [5:0] hi, lo;
   int fails = 0, n_compared = 0;

   cpwm_timer u_dut (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .cpwm_mode(cpwm_mode),
      .buffer_en(buffer_en), .preset_we(preset_we), .lead_preset(lead_preset),
      .lag_preset(lag_preset), .ceiling_compare(ceiling_compare), .cmp_we(cmp_we),
      .cmp_wdata(cmp_wdata), .buf_wdata(buf_wdata), .buf_we(buf_we),
      .polarity_sel_lead(polarity_sel_lead), .polarity_sel_lag(polarity_sel_lag),
      .match_a_clr(match_a_clr), .wrap_clr(wrap_clr), .quad_mode(quad_mode),
      .quad_in_a(quad_in_a), .quad_in_b(quad_in_b), .clear_src(clear_src),
      .quad_compare_a(quad_compare_a), .quad_compare_b(quad_compare_b),
      .quad_flags_clr(quad_flags_clr), .lead_counter(lead_counter), .lag_counter(lag_counter),
      .count_dir(count_dir), .active_compares(active_compares), .match_a_flag(match_a_flag),
      .wrap_flag(wrap_flag), .pwm_pins_enabled(pwm_pins_enabled), .pwm_out(pwm_out),
      .quadrature_counter(quadrature_counter), .quad_status(quad_status)
   );
   cpwm_quad_source u_enc (.ref_clk(ref_clk), .quad_in_a(quad_in_a), .quad_in_b(quad_in_b));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Drive and sample one small delay after the edge so updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Run in one direction, tracking pin levels; bounded so a stuck counter ends it
   task automatic run_while(input cpwm_dir_type d, input bit margin);
      for (int i = 0; i < 60 && count_dir === d; i++) begin
         if (margin) `CHK("margin", 16'h0004, 16'(lead_counter - lag_counter))
         hi |= pwm_out;
         lo |= ~pwm_out;
         tick(1);
      end
   endtask

   task automatic test_cpwm();
      `CHK("pins_idle", 1'b0, pwm_pins_enabled)
      lead_preset = 16'h0004;
      ceiling_compare = 16'h0014;
      cmp_wdata = '{16'h000a, 16'h000c, 16'h000e};
      preset_we = 1'b1;
      cmp_we = 1'b1;
      tick(1);
      preset_we = 1'b0;
      cmp_we = 1'b0;
      cpwm_mode = 1'b1;
      hi = '0;
      lo = '0;
      tick(1);
      `CHK("pins_on", 1'b1, pwm_pins_enabled)
      run_while(CPWM_DIR_UP, 1'b1);
      `CHK("top", 16'h0015, 16'(lead_counter + 16'h0001))
      `CHK("match_up", 1'b1, match_a_flag)
      `CHK("wrap_up", 1'b0, wrap_flag)
      match_a_clr = 1'b1;
      tick(1);
      match_a_clr = 1'b0;
      run_while(CPWM_DIR_DOWN, 1'b0);
      `CHK("match_down", 1'b0, match_a_flag)
      `CHK("wrap_under", 1'b1, wrap_flag)
      wrap_clr = 1'b1;
      tick(1);
      wrap_clr = 1'b0;
      `CHK("wrap_clear", 1'b0, wrap_flag)
      `CHK("pins_high", 6'h3f, hi)
      `CHK("pins_low", 6'h3f, lo)
      $display("test_cpwm done");
   endtask

   task automatic test_duty();
      buffer_en = 1'b1;
      buf_wdata = '{16'h0030, 16'h000c, 16'h000e};
      buf_we = 1'b1;
      tick(1);
      buf_we = 1'b0;
      `CHK("held", 16'h000a, active_compares.phase_one_compare)
      run_while(CPWM_DIR_UP, 1'b1);
      tick(1);
      `CHK("copied", buf_wdata, active_compares)
      tick(2);
      hi = '0;
      lo = '0;
      run_while(CPWM_DIR_DOWN, 1'b0);
      run_while(CPWM_DIR_UP, 1'b1);
      `CHK("flat", 2'h0, 2'(hi[5:4] & lo[5:4]))
      `CHK("others", 4'hf, 4'(hi[3:0] & lo[3:0]))
      // Restore after the next underflow so both moves use the up-to-down transfer
      run_while(CPWM_DIR_DOWN, 1'b0);
      buf_wdata = '{16'h000a, 16'h000c, 16'h000e};
      buf_we = 1'b1;
      tick(1);
      buf_we = 1'b0;
      run_while(CPWM_DIR_UP, 1'b1);
      `CHK("restored", 16'h000a, active_compares.phase_one_compare)
      $display("test_duty done");
   endtask

   task automatic test_quad();
      logic [15:0] base;
      cpwm_mode = 1'b0;
      quad_mode = 1'b1;
      quad_compare_b = 16'h0020;
      tick(2);
      base = quadrature_counter;
      u_enc.move(8, 1'b1);
      tick(3);
      `CHK("quad_up", 16'(base + 16'h0008), quadrature_counter)
      u_enc.move(11, 1'b0);
      tick(3);
      `CHK("quad_down", 16'(base - 16'h0003), quadrature_counter)
      `CHK("quad_flags", 3'h5, quad_status)
      quad_flags_clr = 1'b1;
      tick(1);
      quad_flags_clr = 1'b0;
      `CHK("quad_clear", 3'h0, quad_status)
      $display("test_quad done");
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Whole run is a few hundred cycles; this bound leaves wide slack
   initial begin
      #50000;
      fails++;
      conclude();
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      tick(1);
      test_cpwm();
      test_duty();
      test_quad();
      conclude();
   end
endmodule
